// ---- logic/dmamh_top.sv ----
// Upper DMA controller mask, scratch/soft reset and upper page registers
`timescale 1ns/1ns
`default_nettype none
module dmamh_top #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              ce_in,
   input  wire logic [ADDR_W-1:0] io_addr_in,
   input  wire logic [DATA_W-1:0] io_wdata_in,
   input  wire logic              io_wr_in,
   input  wire logic              io_rd_in,
   output logic      [DATA_W-1:0] io_rdata_out,
   output logic                   io_hit_out,
   input  wire logic [7:0]        base_wr_in,
   input  wire logic [7:0]        low_page_wr_in,
   input  wire logic              m2m_valid_in,
   input  wire logic [DATA_W-1:0] m2m_data_in,
   input  wire logic              byte_access_in,
   input  wire logic              byte_clear_in,
   input  wire logic [3:0]        dreq_in,
   output logic      [3:0]        dreq_accepted_out,
   output logic      [3:0]        mask_out,
   output logic                   ctrl_reset_out,
   output logic                   byte_high_out,
   output logic      [7:0]        page_ch0_out,
   output logic      [7:0]        page_ch1_out,
   output logic      [7:0]        page_ch2_out,
   output logic      [7:0]        page_ch3_out,
   output logic      [7:0]        page_ch5_out,
   output logic      [7:0]        page_ch6_out,
   output logic      [7:0]        page_ch7_out
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Channel index of an upper page port, or 8 when no match
   function automatic logic [3:0] page_sel(input logic [ADDR_W-1:0] a);
      logic [15:0] aa;
      aa = 16'(a);
      case (aa)
         dmamh_pkg::UPPER_PAGE_CH0_PORT: page_sel = 4'h0;
         dmamh_pkg::UPPER_PAGE_CH1_PORT: page_sel = 4'h1;
         dmamh_pkg::UPPER_PAGE_CH2_PORT: page_sel = 4'h2;
         dmamh_pkg::UPPER_PAGE_CH3_PORT: page_sel = 4'h3;
         dmamh_pkg::UPPER_PAGE_CH5_PORT: page_sel = 4'h5;
         dmamh_pkg::UPPER_PAGE_CH6_PORT: page_sel = 4'h6;
         dmamh_pkg::UPPER_PAGE_CH7_PORT: page_sel = 4'h7;
         default:                        page_sel = 4'h8;
      endcase
   endfunction : page_sel

   function automatic logic is_port(input logic [ADDR_W-1:0] a,
                                    input logic [15:0]       p);
      is_port = (16'(a) == p);
   endfunction : is_port

   logic [3:0] wr_sel;
   logic [3:0] rd_sel;
   logic       soft_reset;
   logic       unmask_wr;
   logic       mask_wr;
   logic       scratch_rd;
   dmamh_pkg::dmamh_acc_t acc;

   always_comb begin
      acc = dmamh_pkg::DMAMH_ACC_NONE;
      if (io_wr_in) begin
         acc = dmamh_pkg::DMAMH_ACC_WRITE;
      end else if (io_rd_in) begin
         acc = dmamh_pkg::DMAMH_ACC_READ;
      end
   end

   always_comb begin
      wr_sel     = 4'h8;
      rd_sel     = 4'h8;
      soft_reset = 1'b0;
      unmask_wr  = 1'b0;
      mask_wr    = 1'b0;
      scratch_rd = 1'b0;
      case (acc)
         dmamh_pkg::DMAMH_ACC_WRITE: begin
            wr_sel     = page_sel(io_addr_in);
            soft_reset = is_port(io_addr_in,
                            dmamh_pkg::SCRATCH_OR_SOFT_RESET_PORT);
            unmask_wr  = is_port(io_addr_in,
                            dmamh_pkg::UNMASK_ALL_PORT);
            mask_wr    = is_port(io_addr_in,
                            dmamh_pkg::CHANNEL_MASK_BITS_PORT);
         end
         dmamh_pkg::DMAMH_ACC_READ: begin
            rd_sel     = page_sel(io_addr_in);
            scratch_rd = is_port(io_addr_in,
                            dmamh_pkg::SCRATCH_OR_SOFT_RESET_PORT);
         end
         default: begin
            wr_sel = 4'h8;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Mask, scratch and byte flop state
   // ----------------------------------------------------------------
   logic [3:0]        mask_q;
   logic [3:0]        mask_d;
   logic [DATA_W-1:0] scratch_q;
   logic [DATA_W-1:0] scratch_d;
   logic              byte_q;
   logic              byte_d;

   always_comb begin
      mask_d    = mask_q;
      scratch_d = scratch_q;
      byte_d    = byte_q;
      if (soft_reset) begin
         mask_d    = dmamh_pkg::MASK_RESET;
         scratch_d = DATA_W'(dmamh_pkg::SCRATCH_RESET);
         byte_d    = 1'b0;
      end else begin
         if (unmask_wr) begin
            mask_d = 4'h0;
         end else if (mask_wr) begin
            mask_d = io_wdata_in[dmamh_pkg::MASK_FIELD_LSB +:
                                 dmamh_pkg::MASK_FIELD_W];
         end
         if (m2m_valid_in) begin
            scratch_d = m2m_data_in;
         end
         if (byte_clear_in) begin
            byte_d = 1'b0;
         end else if (byte_access_in) begin
            byte_d = ~byte_q;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mask_q    <= dmamh_pkg::MASK_RESET;
         scratch_q <= DATA_W'(dmamh_pkg::SCRATCH_RESET);
         byte_q    <= 1'b0;
      end else if (ce_in) begin
         mask_q    <= mask_d;
         scratch_q <= scratch_d;
         byte_q    <= byte_d;
      end
   end

   // ----------------------------------------------------------------
   // Request gating
   // ----------------------------------------------------------------
   logic [3:0] dreq_s1_q;
   logic [3:0] dreq_s2_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         dreq_s1_q <= 4'h0;
         dreq_s2_q <= 4'h0;
      end else if (ce_in) begin
         dreq_s1_q <= dreq_in;
         dreq_s2_q <= dreq_s1_q;
      end
   end

   // Bit 0 is the cascade input and passes through the same mask
   assign dreq_accepted_out = dreq_s2_q & ~mask_q;
   assign mask_out          = mask_q;
   assign ctrl_reset_out    = soft_reset & ce_in;
   assign byte_high_out     = byte_q;

   // ----------------------------------------------------------------
   // Upper page registers
   // ----------------------------------------------------------------
   logic [7:0] page_q [dmamh_pkg::NUM_CHANNELS];

   genvar g;
   generate
      for (g = 0; g < dmamh_pkg::NUM_CHANNELS; g++) begin : g_page
         if (g == dmamh_pkg::CASCADE_CHANNEL) begin : g_none
            assign page_q[g] = 8'h00;
         end else begin : g_reg
            dmamh_page_reg #(
               .WIDTH (8)
            ) u_page (
               .clk_in   (clk_in),
               .rst_n_in (rst_n_in),
               .ce_in    (ce_in),
               .wr_in    (wr_sel == 4'(g)),
               .clr_in   (base_wr_in[g] | low_page_wr_in[g]),
               .data_in  (8'(io_wdata_in)),
               .page_out (page_q[g])
            );
         end
      end
   endgenerate

   assign page_ch0_out = page_q[0];
   assign page_ch1_out = page_q[1];
   assign page_ch2_out = page_q[2];
   assign page_ch3_out = page_q[3];
   assign page_ch5_out = page_q[5];
   assign page_ch6_out = page_q[6];
   assign page_ch7_out = page_q[7];

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic              hit_q;
   logic              hit_d;

   always_comb begin
      rdata_d = {DATA_W{1'b0}};
      hit_d   = 1'b0;
      if (scratch_rd) begin
         rdata_d = scratch_q;
         hit_d   = 1'b1;
      end else if (rd_sel != 4'h8) begin
         rdata_d = DATA_W'(page_q[rd_sel[2:0]]);
         hit_d   = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= {DATA_W{1'b0}};
         hit_q   <= 1'b0;
      end else if (ce_in) begin
         rdata_q <= rdata_d;
         hit_q   <= hit_d;
      end
   end

   assign io_rdata_out = rdata_q;
   assign io_hit_out   = hit_q;
endmodule : dmamh_top
`default_nettype wire

// ---- logic/dmamh_pkg.sv ----
// Package of port addresses, field positions and reset values
package dmamh_pkg;
   // ----------------------------------------------------------------
   // I/O port addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] SCRATCH_OR_SOFT_RESET_PORT = 16'h00da;
   localparam logic [15:0] UNMASK_ALL_PORT            = 16'h00dc;
   localparam logic [15:0] CHANNEL_MASK_BITS_PORT     = 16'h00de;
   localparam logic [15:0] UPPER_PAGE_CH0_PORT        = 16'h0487;
   localparam logic [15:0] UPPER_PAGE_CH1_PORT        = 16'h0483;
   localparam logic [15:0] UPPER_PAGE_CH2_PORT        = 16'h0481;
   localparam logic [15:0] UPPER_PAGE_CH3_PORT        = 16'h0482;
   localparam logic [15:0] UPPER_PAGE_CH5_PORT        = 16'h048b;
   localparam logic [15:0] UPPER_PAGE_CH6_PORT        = 16'h0489;
   localparam logic [15:0] UPPER_PAGE_CH7_PORT        = 16'h048a;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int         MASK_FIELD_LSB   = 0;
   localparam int         MASK_FIELD_W     = 4;
   localparam logic [3:0] MASK_RESET       = 4'hf;
   localparam logic [7:0] UPPER_PAGE_RESET = 8'h00;
   localparam logic [7:0] SCRATCH_RESET    = 8'h00;
   localparam int         NUM_CHANNELS     = 8;
   localparam int         CASCADE_CHANNEL  = 4;

   typedef enum logic [1:0] {
      DMAMH_ACC_NONE,
      DMAMH_ACC_WRITE,
      DMAMH_ACC_READ
   } dmamh_acc_t;
endpackage : dmamh_pkg

// ---- logic/dmamh_page_reg.sv ----
// One per-channel upper page register with auto-clear
`timescale 1ns/1ns
`default_nettype none
module dmamh_page_reg #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire logic             wr_in,
   input  wire logic             clr_in,
   input  wire logic [WIDTH-1:0] data_in,
   output logic      [WIDTH-1:0] page_out
);
   logic [WIDTH-1:0] page_q;
   logic [WIDTH-1:0] page_d;

   always_comb begin
      page_d = page_q;
      if (clr_in) begin
         page_d = WIDTH'(dmamh_pkg::UPPER_PAGE_RESET);
      end else if (wr_in) begin
         page_d = data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         page_q <= WIDTH'(dmamh_pkg::UPPER_PAGE_RESET);
      end else if (ce_in) begin
         page_q <= page_d;
      end
   end

   assign page_out = page_q;
endmodule : dmamh_page_reg
`default_nettype wire

// ---- tb/dmamh_asserts.sv ----
// Checker of mask, soft reset and upper page port behaviour
`timescale 1ns/1ns
`default_nettype none
module dmamh_asserts (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        ce_in,
   input wire logic [15:0] io_addr_in,
   input wire logic [7:0]  io_wdata_in,
   input wire logic        io_wr_in,
   input wire logic        io_rd_in,
   input wire logic [7:0]  io_rdata_out,
   input wire logic        io_hit_out,
   input wire logic [7:0]  base_wr_in,
   input wire logic [7:0]  low_page_wr_in,
   input wire logic [3:0]  dreq_accepted_out,
   input wire logic [3:0]  mask_out,
   input wire logic        ctrl_reset_out,
   input wire logic [7:0]  page_ch2_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic       wr;
   logic       rd;
   logic       clr2;
   logic [3:0] nib;
   assign wr   = ce_in && io_wr_in;
   assign rd   = ce_in && io_rd_in && !io_wr_in;
   assign clr2 = base_wr_in[2] || low_page_wr_in[2];
   assign nib  = io_wdata_in[3:0];
   property p_soft; wr && io_addr_in == 16'h00da
      |-> ctrl_reset_out ##1 mask_out == 4'hf; endproperty
   property p_unmask; wr && io_addr_in == 16'h00dc |=> mask_out == 4'h0;
   endproperty
   property p_load; wr && io_addr_in == 16'h00de
      |=> mask_out == $past(nib); endproperty
   property p_accept; (dreq_accepted_out & mask_out) == 4'h0; endproperty
   property p_clr; ce_in && clr2 |=> page_ch2_out == 8'h00; endproperty
   property p_pwr; wr && io_addr_in == 16'h0481 && !clr2
      |=> page_ch2_out == $past(io_wdata_in); endproperty
   property p_wo; rd && (io_addr_in == 16'h00dc || io_addr_in == 16'h00de)
      |=> !io_hit_out && io_rdata_out == 8'h00; endproperty
   property p_prd; rd && io_addr_in == 16'h0481
      |=> io_hit_out && io_rdata_out == $past(page_ch2_out); endproperty
   property p_idle; ce_in && !io_rd_in
      |=> !io_hit_out && io_rdata_out == 8'h00; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   a_unmask: assert property (p_unmask) else $error("unmask");
   a_load: assert property (p_load) else $error("mask load");
   a_accept: assert property (p_accept) else $error("accept");
   a_clr: assert property (p_clr) else $error("page clear");
   a_pwr: assert property (p_pwr) else $error("page write");
   a_wo: assert property (p_wo) else $error("write-only read");
   a_prd: assert property (p_prd) else $error("page read");
   a_idle: assert property (p_idle) else $error("read data idle");
   c_soft: cover property (wr && io_addr_in == 16'h00da);
   c_clr: cover property (ce_in && clr2);
   c_acc: cover property (dreq_accepted_out != 4'h0);
endmodule : dmamh_asserts
bind dmamh_top dmamh_asserts u_asserts (.clk_in, .rst_n_in, .ce_in,
   .io_addr_in, .io_wdata_in, .io_wr_in, .io_rd_in, .io_rdata_out,
   .io_hit_out, .base_wr_in, .low_page_wr_in, .dreq_accepted_out,
   .mask_out, .ctrl_reset_out, .page_ch2_out);
`default_nettype wire

// ---- tb/dmamh_host.sv ----
// Host processor model issuing single byte I/O port accesses
`timescale 1ns/1ns
`default_nettype none
module dmamh_host (
   input  wire logic        clk_in,
   input  wire logic [7:0]  rdata_in,
   input  wire logic        hit_in,
   output logic      [15:0] addr_out,
   output logic      [7:0]  wdata_out,
   output logic             wr_out,
   output logic             rd_out
);
   initial begin
      addr_out = 16'h0000;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // One strobe cycle; returns {hit, data} taken in the answer cycle
   task automatic access(input logic w, input logic [15:0] a,
                         input logic [7:0] d, output logic [8:0] r);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = w;
      rd_out = !w;
      @(negedge clk_in);
      r = {hit_in, rdata_in};
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : access
endmodule : dmamh_host
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the upper DMA mask and page block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
   miscompares++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   logic clk_in = 1'b0;
   logic rst_n_in, wr, rd, hit, m2m_v, bacc, bclr, crst, bhi, ce;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, m2m_d, base_wr, low_wr;
   logic [7:0]  pg [8];
   logic [3:0]  dreq, acc, mask;
   logic [15:0] pa [8];
   int          miscompares = 0;
   int          n_compared = 0;
   dmamh_host u_host (.clk_in(clk_in), .rdata_in(rdata), .hit_in(hit),
      .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   dmamh_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd),
      .io_rdata_out(rdata), .io_hit_out(hit), .base_wr_in(base_wr),
      .low_page_wr_in(low_wr), .m2m_valid_in(m2m_v), .m2m_data_in(m2m_d),
      .byte_access_in(bacc), .byte_clear_in(bclr), .dreq_in(dreq),
      .dreq_accepted_out(acc), .mask_out(mask), .ctrl_reset_out(crst),
      .byte_high_out(bhi), .page_ch0_out(pg[0]), .page_ch1_out(pg[1]),
      .page_ch2_out(pg[2]), .page_ch3_out(pg[3]), .page_ch5_out(pg[5]),
      .page_ch6_out(pg[6]), .page_ch7_out(pg[7]));
   always #5 clk_in = ~clk_in;
   function automatic logic [3:0] exp_acc(logic [7:0] d, logic [3:0] q);
      return q & ~d[3:0];
   endfunction : exp_acc
   task automatic end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   initial begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      end_sim();
   end
   initial begin
      logic [8:0] r;
      logic [7:0] d;
      pa = '{16'h0487, 16'h0483, 16'h0481, 16'h0482, 16'h0000, 16'h048b,
             16'h0489, 16'h048a};
      d = 8'($urandom(32'h0000_b6cc));
      {rst_n_in, m2m_v, bacc, bclr, base_wr, low_wr} = '0;
      ce = 1'b1;
      {m2m_d, dreq} = '0;
      repeat (20) @(negedge clk_in);
      rst_n_in = 1'b1;
      `CHK(mask, 4'hf)
      u_host.access(1'b0, 16'h00da, 8'h00, r);
      `CHK(r, 9'h100)
      for (int c = 0; c < 8; c++) begin
         if (c == 4) continue;
         `CHK(pg[c], 8'h00)
         d = 8'($urandom);
         u_host.access(1'b1, pa[c], d, r);
         `CHK(pg[c], d)
         @(negedge clk_in);
         base_wr[c] = c[0];
         low_wr[c] = !c[0];
         @(negedge clk_in);
         {base_wr, low_wr} = '0;
         `CHK(pg[c], 8'h00)
         u_host.access(1'b1, pa[c], ~d, r);
         u_host.access(1'b0, pa[c], 8'h00, r);
         `CHK(r, {1'b1, ~d})
      end
      u_host.access(1'b0, 16'h0484, 8'h00, r);
      `CHK(r, 9'h000)
      u_host.access(1'b1, 16'h00dc, 8'h00, r);
      `CHK(mask, 4'h0)
      u_host.access(1'b0, 16'h00dc, 8'h00, r);
      `CHK(r, 9'h000)
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hf0 : 8'($urandom);
         u_host.access(1'b1, 16'h00de, d, r);
         `CHK(mask, d[3:0])
         dreq = 4'($urandom);
         repeat (3) @(negedge clk_in);
         `CHK(acc, exp_acc(d, dreq))
      end
      m2m_v = 1'b1;
      m2m_d = 8'h3c;
      @(negedge clk_in);
      m2m_d = 8'ha5;
      @(negedge clk_in);
      {m2m_v, m2m_d} = 9'h05a;
      u_host.access(1'b0, 16'h00da, 8'h00, r);
      `CHK(r, 9'h1a5)
      bacc = 1'b1;
      @(negedge clk_in);
      bacc = 1'b0;
      `CHK(bhi, 1'b1)
      bclr = 1'b1;
      bacc = 1'b1;
      @(negedge clk_in);
      {bclr, bacc} = 2'b00;
      `CHK(bhi, 1'b0)
      bacc = 1'b1;
      @(negedge clk_in);
      bacc = 1'b0;
      `CHK(bhi, 1'b1)
      ce = 1'b0;
      u_host.access(1'b1, 16'h00dc, 8'h00, r);
      `CHK(mask, d[3:0])
      ce = 1'b1;
      u_host.access(1'b1, 16'h00dc, 8'h00, r);
      u_host.access(1'b1, 16'h00da, 8'h5a, r);
      `CHK(mask, 4'hf)
      `CHK(bhi, 1'b0)
      u_host.access(1'b0, 16'h00da, 8'h00, r);
      `CHK(r, 9'h100)
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
